// *** rtl/hdlc_transmit_packet_controller.sv ***
// hdlc transmit packet controller: host registers, 256-byte queue, framing serializer
// Notes on behaviour
// - space available when free bytes reach eight times threshold plus one
// - inhibit bit lets current packet finish, then starts no new packet
// - normally the complemented crc-16 follows the packet data
// - inject bit sends the plain crc instead; ignored when check bytes disabled
// - idle fill is repeated 7Eh flags, or all ones when selected
// - bit order select picks lsb-first or msb-first serialisation of data
// - output invert flips every bit leaving the serializer
// - check disable sends packets with no check bytes at all
// - queue reset empties queue, halts transfer, powers ram down, ignores writes
// - after queue reset, discard writes until ram awake and new packet start
// - upper byte write pushes data byte and end marker as one entry
// - write port always reads as zero
// - six-bit field gives whole eight-byte groups of free space
// - full bit set only when all 256 bytes are stored
// - empty bit set exactly when no bytes are stored
// - space-available bit follows free space against programmed threshold
// - empty and space latches set on rising edge and on reset release
// - packet-end latch set when an end-marked entry leaves the queue
// - each latch interrupts only with its enable and the port enable
`timescale 1ns/1ps
`include "hdlc_tx_map.svh"

module hdlc_transmit_packet_controller #(
  parameter int DEPTH     = 256,
  parameter int WAKE_CYCS = 16
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire hdlc_tx_pkg::host_req_t host,
  output logic [15:0]               rdata,
  input  wire logic                 port_interrupt_enable,
  output logic                      irq,
  input  wire logic                 bit_req,
  output logic                      tx_bit,
  output logic                      ram_power_down
);
  import hdlc_tx_pkg::*;

  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH != 256 || WAKE_CYCS < 1 || WAKE_CYCS > 65535)
      $error("unsupported queue depth or wake count");
  end

  // --------------------------------------------------------------
  // host registers
  // --------------------------------------------------------------
  logic [15:0] ctl_r, ctl_nxt, lat_r, lat_nxt, ie_r, ie_nxt, rdata_r, rdata_nxt;
  logic [15:0] live;
  logic [15:0] wake_r, wake_nxt;
  logic        hunt_r, hunt_nxt, open_r, open_nxt, qrst_d_r;
  logic        empty_d_r, space_d_r;
  logic        push, ovf, unf, pend_pop;
  logic [AW:0] count_r, count_nxt, free;
  logic        q_empty, q_full, space_ok;
  logic        qrst, host_wr, accept;

  assign qrst    = ctl_r[`CTL_QRST];
  assign host_wr = host.wr_hi && host.addr == `TX_WRITE_OFS;
  assign free    = (AW+1)'(DEPTH) - count_r;
  assign q_full  = count_r == (AW+1)'(DEPTH);
  assign q_empty = count_r == '0;
  assign space_ok = free >= (AW+1)'({ctl_r[`CTL_THR_MSB:`CTL_THR_LSB], 3'h0}) + (AW+1)'(1);

  always_comb
  begin
    live = '0;
    live[`ST_GRP_MSB:`ST_GRP_LSB] = 6'(free >> `GROUP_SHIFT);
    live[`ST_FULL]  = q_full;
    live[`ST_EMPTY] = q_empty;
    live[`ST_SPACE] = space_ok;
  end

  // upper byte pushes entry
  // a packet start that arrives in the very cycle the hunt ends is kept, not thrown away
  assign accept = !qrst && (!hunt_r || (wake_r == '0 && !open_r));
  assign push   = host_wr && accept && !q_full;
  assign ovf    = host_wr && accept && q_full;

  always_comb
  begin
    ctl_nxt  = ctl_r;
    ie_nxt   = ie_r;
    lat_nxt  = lat_r;
    wake_nxt = wake_r;
    hunt_nxt = hunt_r;
    open_nxt = open_r;
    if (host.addr == `TX_CONTROL_OFS && host.wr_hi)
      ctl_nxt[15:8] = host.wdata[15:8] & 8'(`CTL_MASK >> 8);
    if (host.addr == `TX_CONTROL_OFS && host.wr_lo)
      ctl_nxt[7:0] = host.wdata[7:0] & 8'(`CTL_MASK);
    if (host.addr == `TX_IE_OFS && host.wr_lo)
      ie_nxt[7:0] = host.wdata[7:0] & 8'(`IE_MASK);
    if (host.addr == `TX_LATCHED_OFS && host.wr_lo)
      lat_nxt[7:0] = lat_r[7:0] & ~host.wdata[7:0];
    if (qrst)
    begin
      wake_nxt = 16'(WAKE_CYCS);
      hunt_nxt = 1'b1;
      open_nxt = 1'b0;
    end
    else
    begin
      if (wake_r != '0)
        wake_nxt = wake_r - 16'h0001;
      if (host_wr)
        open_nxt = !host.wdata[`WR_END];
      if (wake_r == '0 && !open_r)
        hunt_nxt = 1'b0;
    end
    // event sets win over clears
    if (ovf)
      lat_nxt[`LT_OVF] = 1'b1;
    if (unf)
      lat_nxt[`LT_UNF] = 1'b1;
    if (pend_pop)
      lat_nxt[`LT_PEND] = 1'b1;
    if ((q_empty && !empty_d_r) || (qrst_d_r && !qrst))
      lat_nxt[`LT_EMPTY] = 1'b1;
    if ((space_ok && !space_d_r) || (qrst_d_r && !qrst))
      lat_nxt[`LT_SPACE] = 1'b1;
    rdata_nxt = rdata_r;
    if (host.rd)
    begin
      unique case (host.addr)
        `TX_CONTROL_OFS: rdata_nxt = ctl_r;
        `TX_LIVE_OFS:    rdata_nxt = live;
        `TX_LATCHED_OFS: rdata_nxt = lat_r;
        `TX_IE_OFS:      rdata_nxt = ie_r;
        default:         rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctl_r     <= `CTL_RESET;
      ie_r      <= '0;
      lat_r     <= '0;
      rdata_r   <= '0;
      wake_r    <= '0;
      hunt_r    <= 1'b0;
      open_r    <= 1'b0;
      qrst_d_r  <= 1'b0;
      empty_d_r <= 1'b1;
      space_d_r <= 1'b1;
    end
    else
    begin
      ctl_r     <= ctl_nxt;
      ie_r      <= ie_nxt;
      lat_r     <= lat_nxt;
      rdata_r   <= rdata_nxt;
      wake_r    <= wake_nxt;
      hunt_r    <= hunt_nxt;
      open_r    <= open_nxt;
      qrst_d_r  <= qrst;
      empty_d_r <= q_empty;
      space_d_r <= space_ok;
    end
  end

  assign rdata = rdata_r;
  assign irq = port_interrupt_enable && |(lat_r & ie_r);
  assign ram_power_down = qrst;

  // --------------------------------------------------------------
  // 256-entry queue and two-entry buffer
  // --------------------------------------------------------------
  // byte plus end marker
  entry_t        mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic          q_pop;
  entry_t        skid [2];
  logic [1:0]    sc_r, sc_nxt;
  logic          sh_r, sh_nxt;
  logic          b_valid, b_take;
  entry_t        b_head;

  assign q_pop    = !q_empty && sc_r != 2'h2 && !qrst;
  assign pend_pop = q_pop && mem[rp_r].last;
  assign b_valid  = sc_r != 2'h0;
  assign b_head   = skid[sh_r];

  always_comb
  begin
    wp_nxt    = wp_r;
    rp_nxt    = rp_r;
    count_nxt = count_r;
    sc_nxt    = sc_r;
    sh_nxt    = sh_r;
    if (qrst)
    begin
      wp_nxt    = '0;
      rp_nxt    = '0;
      count_nxt = '0;
      sc_nxt    = '0;
      sh_nxt    = '0;
    end
    else
    begin
      if (push)
        wp_nxt = wp_r + AW'(1);
      if (q_pop)
        rp_nxt = rp_r + AW'(1);
      count_nxt = count_r + (AW+1)'(push) - (AW+1)'(q_pop);
      sc_nxt    = sc_r + 2'(q_pop) - 2'(b_take);
      if (b_take)
        sh_nxt = !sh_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= '{last: host.wdata[`WR_END], data: host.wdata[`WR_DATA_MSB:`WR_DATA_LSB]};
    if (q_pop)
      // tail slot sits one past the head whenever one entry waits, whether or not the head leaves now
      skid[sh_r ^ (sc_r != 2'h0)] <= mem[rp_r];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wp_r    <= '0;
      rp_r    <= '0;
      count_r <= '0;
      sc_r    <= '0;
      sh_r    <= '0;
    end
    else
    begin
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      count_r <= count_nxt;
      sc_r    <= sc_nxt;
      sh_r    <= sh_nxt;
    end
  end

  // --------------------------------------------------------------
  // serializer
  // --------------------------------------------------------------
  ser_state_t  st_r, st_nxt;
  logic [15:0] sr_r, sr_nxt, crc_r, crc_nxt;
  logic [4:0]  left_r, left_nxt;
  logic [2:0]  ones_r, ones_nxt;
  logic        stuff_r, stuff_nxt, last_r, last_nxt, bit_r, bit_nxt;
  logic [7:0]  fill, ordered;

  assign fill = ctl_r[`CTL_IDLE] ? `IDLE_ONES : `HDLC_FLAG;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      ordered[i] = ctl_r[`CTL_ORDER] ? b_head.data[7-i] : b_head.data[i];
  end

  always_comb
  begin
    st_nxt    = st_r;
    sr_nxt    = sr_r;
    crc_nxt   = crc_r;
    left_nxt  = left_r;
    ones_nxt  = ones_r;
    stuff_nxt = stuff_r;
    last_nxt  = last_r;
    bit_nxt   = bit_r;
    b_take    = 1'b0;
    unf       = 1'b0;
    if (qrst)
    begin
      st_nxt    = S_IDLE;
      sr_nxt    = {8'h00, fill};
      left_nxt  = 5'h08;
      ones_nxt  = '0;
      stuff_nxt = 1'b0;
    end
    else if (bit_req)
    begin
      if (ones_r == `STUFF_RUN)
      begin
        bit_nxt  = ctl_r[`CTL_INVERT];
        ones_nxt = '0;
      end
      else
      begin
        bit_nxt  = sr_r[0] ^ ctl_r[`CTL_INVERT];
        sr_nxt   = sr_r >> 1;
        left_nxt = left_r - 5'h01;
        // run count restarts outside stuffed fields so flags never seed the next frame's count
        ones_nxt = (stuff_r && sr_r[0]) ? ones_r + 3'h1 : 3'h0;
        if (st_r == S_DATA && !ctl_r[`CTL_NOFCS])
          crc_nxt = (crc_r >> 1) ^ ((crc_r[0] ^ sr_r[0]) ? `CRC_POLY : 16'h0000);
        if (left_r == 5'h01)
        begin
          left_nxt  = 5'h08;
          stuff_nxt = 1'b0;
          sr_nxt    = {8'h00, `HDLC_FLAG};
          unique case (st_r)
            S_IDLE, S_CLOSE:
            begin
              if (b_valid && !ctl_r[`CTL_INHIBIT])
                st_nxt = S_OPEN;
              else
              begin
                st_nxt = S_IDLE;
                sr_nxt = {8'h00, fill};
              end
            end
            S_OPEN, S_DATA:
            begin
              if (st_r == S_DATA && last_r)
              begin
                if (ctl_r[`CTL_NOFCS])
                  st_nxt = S_CLOSE;
                else
                begin
                  st_nxt   = S_FCS;
                  sr_nxt   = ctl_r[`CTL_INJECT] ? crc_nxt : ~crc_nxt;
                  left_nxt = 5'h10;
                  stuff_nxt = 1'b1;
                end
              end
              else if (b_valid)
              begin
                if (st_r == S_OPEN)
                  crc_nxt = `CRC_INIT;
                st_nxt    = S_DATA;
                sr_nxt    = {8'h00, ordered};
                stuff_nxt = 1'b1;
                last_nxt  = b_head.last;
                b_take    = 1'b1;
              end
              else
              begin
                // starved mid-packet: frame is cut short
                unf    = 1'b1;
                st_nxt = S_CLOSE;
              end
            end
            S_FCS:
              st_nxt = S_CLOSE;
            default:
              st_nxt = S_IDLE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r    <= S_IDLE;
      sr_r    <= {8'h00, `HDLC_FLAG};
      crc_r   <= `CRC_INIT;
      left_r  <= 5'h08;
      ones_r  <= '0;
      stuff_r <= 1'b0;
      last_r  <= 1'b0;
      bit_r   <= 1'b1;
    end
    else
    begin
      st_r    <= st_nxt;
      sr_r    <= sr_nxt;
      crc_r   <= crc_nxt;
      left_r  <= left_nxt;
      ones_r  <= ones_nxt;
      stuff_r <= stuff_nxt;
      last_r  <= last_nxt;
      bit_r   <= bit_nxt;
    end
  end

  assign tx_bit = bit_r;

endmodule : hdlc_transmit_packet_controller

// *** rtl/hdlc_tx_map.svh ***
// register offsets, field positions, reset values and fixed codes of the hdlc transmit controller
`ifndef HDLC_TX_MAP_SVH
`define HDLC_TX_MAP_SVH
`define TX_CONTROL_OFS   8'hA0
`define TX_WRITE_OFS     8'hA2
`define TX_LIVE_OFS      8'hA4
`define TX_LATCHED_OFS   8'hA6
`define TX_IE_OFS        8'hA8
`define CTL_RESET        16'h0800
`define CTL_MASK         16'h1F7F
`define IE_MASK          16'h003F
`define CTL_THR_LSB      8
`define CTL_THR_MSB      12
`define CTL_INHIBIT      6
`define CTL_INJECT       5
`define CTL_IDLE         4
`define CTL_ORDER        3
`define CTL_INVERT       2
`define CTL_NOFCS        1
`define CTL_QRST         0
`define WR_DATA_LSB      8
`define WR_DATA_MSB      15
`define WR_END           0
`define ST_GRP_LSB       8
`define ST_GRP_MSB       13
`define ST_FULL          2
`define ST_EMPTY         1
`define ST_SPACE         0
`define LT_OVF           5
`define LT_UNF           4
`define LT_PEND          3
`define LT_EMPTY         1
`define LT_SPACE         0
`define HDLC_FLAG        8'h7E
`define IDLE_ONES        8'hFF
`define CRC_POLY         16'h8408
`define CRC_INIT         16'hFFFF
`define STUFF_RUN        3'h5
`define GROUP_SHIFT      3
`endif

// *** rtl/hdlc_tx_pkg.sv ***
// types shared by the hdlc transmit controller
package hdlc_tx_pkg;
  typedef struct packed
  {
    logic       last;
    logic [7:0] data;
  } entry_t;

  typedef struct packed
  {
    logic [7:0]  addr;
    logic        wr_hi;
    logic        wr_lo;
    logic        rd;
    logic [15:0] wdata;
  } host_req_t;

  typedef enum logic [2:0]
  {
    S_IDLE  = 3'h0,
    S_OPEN  = 3'h1,
    S_DATA  = 3'h3,
    S_FCS   = 3'h2,
    S_CLOSE = 3'h6
  } ser_state_t;
endpackage : hdlc_tx_pkg

// *** testbench/bit_sink.sv ***
// framer-side model: requests line bits, promptly or at random, and records them
`timescale 1ns/1ps
module bit_sink (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic slow,
  input  wire logic tx_bit,
  output logic      bit_req
);
  logic got_q[$];
  logic req_d;
  initial
  begin
    bit_req = 1'b0;
    req_d   = 1'b0;
  end
  // the answer lands one cycle after its request, so record on the following edge
  always @(posedge clk)
  begin
    if (req_d)
      got_q.push_back(tx_bit);
    req_d   <= bit_req;
    bit_req <= #1 run && (!slow || $urandom_range(1, 0));
  end
endmodule : bit_sink

// *** testbench/hdlc_tx_props.sv ***
// port-level assertions for the hdlc transmit controller
`timescale 1ns/1ps
module hdlc_tx_props
  import hdlc_tx_pkg::*;
#(
  parameter int DEPTH     = 256,
  parameter int WAKE_CYCS = 16
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire host_req_t   host,
  input wire logic [15:0] rdata,
  input wire logic        port_interrupt_enable,
  input wire logic        irq,
  input wire logic        bit_req,
  input wire logic        tx_bit,
  input wire logic        ram_power_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence live_rd_s;
    host.rd && host.addr == 8'hA4;
  endsequence
  sequence ctl_wr_s;
    host.wr_lo && host.addr == 8'hA0;
  endsequence
  wport_zero_a: assert property (host.rd && host.addr == 8'hA2 |=> rdata == 16'h0000)
    else $error("write port read back nonzero");
  power_follows_a: assert property (ctl_wr_s |=> ram_power_down == $past(host.wdata[0]))
    else $error("ram power down does not follow control");
  reset_empties_a: assert property (ram_power_down && $past(ram_power_down) ##0 live_rd_s
    |=> rdata[1] && rdata[13:8] == DEPTH / 8) else $error("queue not empty while held in reset");
  empty_full_a: assert property (live_rd_s |=> !(rdata[1] && rdata[2]))
    else $error("empty and full together");
  empty_groups_a: assert property (live_rd_s ##1 rdata[1] |-> rdata[13:8] == DEPTH / 8)
    else $error("empty queue with wrong group count");
  full_space_a: assert property (live_rd_s ##1 rdata[2] |-> rdata[13:8] == 6'h00 && !rdata[0])
    else $error("full queue reports free space");
  irq_gated_a: assert property (!port_interrupt_enable |-> !irq)
    else $error("irq without port enable");
  bit_hold_a: assert property (!bit_req |=> $stable(tx_bit))
    else $error("line bit moved without request");
  rdata_hold_a: assert property (!host.rd |=> $stable(rdata))
    else $error("read data moved without read");
endmodule : hdlc_tx_props

// *** testbench/testbench.sv ***
// self-checking bench for the hdlc transmit controller
`timescale 1ns/1ps
module testbench;
  import hdlc_tx_pkg::*;
  logic        clk;
  logic        reset;
  host_req_t   host;
  logic [15:0] rdata;
  logic        port_ie;
  logic        irq;
  logic        bit_req;
  logic        tx_bit;
  logic        pdown;
  logic        run;
  logic        slow;
  logic [15:0] v;
  logic [7:0]  pk[3];
  logic        dq[$];
  logic        eq[$];
  int          n_mismatch;
  int          cmp_count;
  int          cyc;
  logic [15:0] ctls[8] = '{16'h0800, 16'h0820, 16'h0808, 16'h0802, 16'h0822, 16'h0804, 16'h0814, 16'h0840};

  hdlc_transmit_packet_controller #(.DEPTH(256), .WAKE_CYCS(4)) dut_u (.clk(clk), .reset(reset), .host(host),
    .rdata(rdata), .port_interrupt_enable(port_ie), .irq(irq), .bit_req(bit_req), .tx_bit(tx_bit),
    .ram_power_down(pdown));
  bit_sink snk_u (.clk(clk), .run(run), .slow(slow), .tx_bit(tx_bit), .bit_req(bit_req));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one access; read data is registered on the taking edge
  task automatic acc(input logic [7:0] a, input logic hi, input logic lo, input logic r, input logic [15:0] d);
    @(posedge clk);
    #1 host = '{a, hi, lo, r, d};
    @(posedge clk);
    #1 host = '0;
    v = rdata;
  endtask : acc

  // destuff the recorded line bits and return the first nonempty frame between two flags
  task automatic grab(input logic inv);
    int   ones;
    logic b;
    logic st;
    ones = 0;
    st   = 1'b0;
    dq.delete();
    foreach (snk_u.got_q[i])
    begin
      b = snk_u.got_q[i] ^ inv;
      if (b)
      begin
        ones++;
        dq.push_back(b);
      end
      else if (ones >= 6)
      begin
        if (ones == 6 && st && dq.size() > 7)
        begin
          repeat (7) void'(dq.pop_back());
          return;
        end
        st = (ones == 6);
        dq.delete();
        ones = 0;
      end
      else
      begin
        if (ones != 5)
          dq.push_back(b);
        ones = 0;
      end
    end
    dq.delete();
  endtask : grab

  function automatic void expect_bits(input logic ord, input logic nofcs, input logic inj);
    logic [15:0] crc;
    logic        b;
    eq.delete();
    crc = 16'hFFFF;
    foreach (pk[i])
      for (int k = 0; k < 8; k++)
      begin
        b = ord ? pk[i][7 - k] : pk[i][k];
        eq.push_back(b);
        crc = (crc >> 1) ^ ((crc[0] ^ b) ? 16'h8408 : 16'h0000);
      end
    if (!inj)
      crc = ~crc;
    if (!nofcs)
      for (int k = 0; k < 16; k++)
        eq.push_back(crc[k]);
  endfunction : expect_bits

  // queue reset first so each case starts clean; a leading all-ones byte forces stuffing
  task automatic frame_case(input logic [15:0] ctl, input logic sl);
    acc(8'hA0, 1'b1, 1'b1, 1'b0, ctl | 16'h0001);
    acc(8'hA0, 1'b1, 1'b1, 1'b0, ctl);
    repeat (6) @(posedge clk);
    snk_u.got_q.delete();
    pk[0] = 8'hFF;
    pk[1] = 8'($urandom);
    pk[2] = 8'($urandom);
    foreach (pk[i])
      acc(8'hA2, 1'b1, 1'b0, 1'b0, {pk[i], 7'h00, 1'(i == 2)});
    slow = sl;
    run  = 1'b1;
    repeat (450) @(posedge clk);
    #1 run = 1'b0;
    grab(ctl[2]);
    expect_bits(ctl[3], ctl[1], ctl[5]);
    if (ctl[6])
      chk(16'(dq.size()), 16'h0000);
    else
    begin
      chk(16'(dq.size()), 16'(eq.size()));
      foreach (eq[i])
        chk(16'(dq[i]), 16'(eq[i]));
    end
    if (ctl[4])
      for (int k = 1; k <= 16; k++)
        chk(16'(snk_u.got_q[snk_u.got_q.size() - k] ^ ctl[2]), 16'h0001);
    $display("frame case %h done", ctl);
  endtask : frame_case

  initial
  begin
    host    = '0;
    port_ie = 1'b0;
    run     = 1'b0;
    slow    = 1'b0;
    reset   = 1'b1;
    void'($urandom(32'haaf0));
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    acc(8'hA0, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v, 16'h0800);
    acc(8'hA4, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v & 16'h3F07, 16'h2003);
    acc(8'hA8, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v, 16'h0000);
    acc(8'hAA, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v, 16'h0000);
    $display("reset values done");
    acc(8'hA0, 1'b1, 1'b1, 1'b0, 16'h0000);
    repeat (260)
      acc(8'hA2, 1'b1, 1'b0, 1'b0, {8'($urandom), 8'h00});
    acc(8'hA4, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v & 16'h3F07, 16'h0004);
    acc(8'hA2, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v, 16'h0000);
    acc(8'hA6, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v & 16'h0020, 16'h0020);
    $display("fill to full done");
    acc(8'hA0, 1'b1, 1'b1, 1'b0, 16'h0801);
    chk(16'(pdown), 16'h0001);
    acc(8'hA6, 1'b0, 1'b1, 1'b0, 16'h003F);
    repeat (3)
      acc(8'hA2, 1'b1, 1'b0, 1'b0, 16'h5501);
    acc(8'hA4, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v & 16'h3F07, 16'h2003);
    acc(8'hA0, 1'b1, 1'b1, 1'b0, 16'h0800);
    acc(8'hA2, 1'b1, 1'b0, 1'b0, 16'h2200);
    acc(8'hA2, 1'b1, 1'b0, 1'b0, 16'h3300);
    acc(8'hA2, 1'b1, 1'b0, 1'b0, 16'h4401);
    acc(8'hA4, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v & 16'h0002, 16'h0002);
    repeat (3)
      acc(8'hA2, 1'b1, 1'b0, 1'b0, 16'h6600);
    acc(8'hA4, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v & 16'h0002, 16'h0000);
    acc(8'hA6, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v & 16'h0003, 16'h0003);
    $display("queue reset done");
    foreach (ctls[i])
      frame_case(ctls[i], 1'(i % 2));
    acc(8'hA6, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v & 16'h0008, 16'h0008);
    acc(8'hA8, 1'b0, 1'b1, 1'b0, 16'h0008);
    port_ie = 1'b1;
    #1 chk(16'(irq), 16'h0001);
    @(posedge clk);
    #1 port_ie = 1'b0;
    #1 chk(16'(irq), 16'h0000);
    acc(8'hA6, 1'b0, 1'b1, 1'b0, 16'h0008);
    acc(8'hA6, 1'b0, 1'b0, 1'b1, 16'h0000);
    chk(v & 16'h0008, 16'h0000);
    $display("latch and irq done");
    tally_and_finish();
  end
endmodule : testbench

bind hdlc_transmit_packet_controller hdlc_tx_props #(.DEPTH(DEPTH), .WAKE_CYCS(WAKE_CYCS)) props_u (
  .clk(clk), .reset(reset), .host(host), .rdata(rdata), .port_interrupt_enable(port_interrupt_enable),
  .irq(irq), .bit_req(bit_req), .tx_bit(tx_bit), .ram_power_down(ram_power_down));
